/* fsb_block_transfer.sv */
// fast serial port: byte data path, block receive/transmit engines, ahb regs
// assumes a byte memory that may stall mem_req for any number of cycles and ends it with a one-cycle mem_ack
//
// Local design decision: the AHB-Lite slave port.
`timescale 1ns/1ps
module fsb_block_transfer #(
  parameter int CLKS_PER_BIT = fsb_pkg::CLKS_PER_BIT,
  parameter int RX_DEPTH = fsb_pkg::RX_FIFO_DEPTH
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [fsb_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [fsb_pkg::DATA_W-1:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [fsb_pkg::DATA_W-1:0] hrdata,
  input wire logic rx_line,
  output logic tx_line,
  output logic mem_req,
  output logic mem_we,
  output logic [fsb_pkg::PTR_W-1:0] mem_addr,
  output logic [fsb_pkg::BYTE_W-1:0] mem_wdata,
  input wire logic [fsb_pkg::BYTE_W-1:0] mem_rdata,
  input wire logic mem_ack,
  output logic irq
);
  import fsb_pkg::*;

  localparam int DIV_W = $clog2(CLKS_PER_BIT + 1);
  localparam int FP_W = $clog2(RX_DEPTH);
  localparam logic [DIV_W-1:0] DIV_FULL = DIV_W'(CLKS_PER_BIT - 1);
  localparam logic [DIV_W-1:0] DIV_HALF = DIV_W'(CLKS_PER_BIT / 2);
  localparam logic [FP_W:0] FIFO_FULL = (FP_W+1)'(RX_DEPTH);
  localparam logic [2:0] LAST_BIT = 3'h7;

  function automatic logic [IDX_W-1:0] idx_of(input logic [ADDR_W-1:0] a);
    idx_of = a[IDX_LSB+IDX_W-1:IDX_LSB];
  endfunction

  function automatic logic [CNT_W-1:0] count_down(input logic [CNT_W-1:0] c);
    // wraps from zero to the finished value
    count_down = (c == CNT_RESET) ? CNT_DONE : c - 1'b1;
  endfunction

  // receive line
  fsb_line_t rx_st_reg, rx_st_next;
  logic [DIV_W-1:0] rx_div_reg, rx_div_next;
  logic [2:0] rx_bit_reg, rx_bit_next;
  logic [BYTE_W-1:0] rx_sh_reg, rx_sh_next;
  logic rx_push;

  always_comb begin
    rx_st_next = rx_st_reg;
    rx_div_next = rx_div_reg;
    rx_bit_next = rx_bit_reg;
    rx_sh_next = rx_sh_reg;
    rx_push = 1'b0;
    case (rx_st_reg)
      LN_IDLE: begin
        if (!rx_line) begin
          rx_st_next = LN_START;
          rx_div_next = DIV_HALF;
        end
      end
      LN_START: begin
        if (rx_div_reg != '0) begin
          rx_div_next = rx_div_reg - 1'b1;
        end else if (!rx_line) begin
          rx_st_next = LN_DATA;
          rx_div_next = DIV_FULL;
          rx_bit_next = '0;
        end else begin
          // glitch, not a start bit
          rx_st_next = LN_IDLE;
        end
      end
      LN_DATA: begin
        if (rx_div_reg != '0) begin
          rx_div_next = rx_div_reg - 1'b1;
        end else begin
          rx_sh_next = {rx_line, rx_sh_reg[BYTE_W-1:1]};
          rx_div_next = DIV_FULL;
          rx_bit_next = rx_bit_reg + 1'b1;
          if (rx_bit_reg == LAST_BIT) begin
            rx_st_next = LN_STOP;
          end
        end
      end
      LN_STOP: begin
        if (rx_div_reg != '0) begin
          rx_div_next = rx_div_reg - 1'b1;
        end else begin
          // framing error drops the byte
          rx_push = rx_line;
          rx_st_next = LN_IDLE;
        end
      end
      default: rx_st_next = LN_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_st_reg <= LN_IDLE;
      rx_div_reg <= '0;
      rx_bit_reg <= '0;
      rx_sh_reg <= '0;
    end else if (ce) begin
      rx_st_reg <= rx_st_next;
      rx_div_reg <= rx_div_next;
      rx_bit_reg <= rx_bit_next;
      rx_sh_reg <= rx_sh_next;
    end
  end

  // receive fifo
  logic [BYTE_W-1:0] rx_mem [RX_DEPTH];
  logic [FP_W-1:0] rx_wp_reg, rx_wp_next, rx_rp_reg, rx_rp_next;
  logic [FP_W:0] rx_cnt_reg, rx_cnt_next;
  logic rx_pop, fifo_full, fifo_empty, fifo_wr;

  assign fifo_full = (rx_cnt_reg == FIFO_FULL);
  assign fifo_empty = (rx_cnt_reg == '0);
  // a byte that finds the fifo full is lost and flagged
  assign fifo_wr = rx_push && !fifo_full;

  always_comb begin
    rx_wp_next = fifo_wr ? rx_wp_reg + 1'b1 : rx_wp_reg;
    rx_rp_next = rx_pop ? rx_rp_reg + 1'b1 : rx_rp_reg;
    rx_cnt_next = rx_cnt_reg + (FP_W+1)'(fifo_wr) - (FP_W+1)'(rx_pop);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_wp_reg <= '0;
      rx_rp_reg <= '0;
      rx_cnt_reg <= '0;
    end else if (ce) begin
      rx_wp_reg <= rx_wp_next;
      rx_rp_reg <= rx_rp_next;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  always_ff @(posedge hclk) begin
    if (ce && fifo_wr) begin
      rx_mem[rx_wp_reg] <= rx_sh_reg;
    end
  end

  // transmit line
  fsb_line_t tx_st_reg, tx_st_next;
  logic [DIV_W-1:0] tx_div_reg, tx_div_next;
  logic [2:0] tx_bit_reg, tx_bit_next;
  logic [BYTE_W-1:0] tx_sh_reg, tx_sh_next;
  logic tx_line_reg, tx_line_next;
  logic tx_take;
  logic tx_hold_vld_reg;
  logic [BYTE_W-1:0] tx_hold_reg;

  always_comb begin
    tx_st_next = tx_st_reg;
    tx_div_next = tx_div_reg;
    tx_bit_next = tx_bit_reg;
    tx_sh_next = tx_sh_reg;
    tx_line_next = tx_line_reg;
    tx_take = 1'b0;
    if (tx_st_reg != LN_IDLE && tx_div_reg != '0) begin
      tx_div_next = tx_div_reg - 1'b1;
    end else begin
      case (tx_st_reg)
        LN_IDLE: begin
          tx_line_next = 1'b1;
          if (tx_hold_vld_reg) begin
            tx_take = 1'b1;
            tx_sh_next = tx_hold_reg;
            tx_line_next = 1'b0;
            tx_div_next = DIV_FULL;
            tx_st_next = LN_START;
          end
        end
        LN_START: begin
          tx_line_next = tx_sh_reg[0];
          tx_div_next = DIV_FULL;
          tx_bit_next = '0;
          tx_st_next = LN_DATA;
        end
        LN_DATA: begin
          tx_div_next = DIV_FULL;
          if (tx_bit_reg == LAST_BIT) begin
            tx_line_next = 1'b1;
            tx_st_next = LN_STOP;
          end else begin
            tx_sh_next = {1'b0, tx_sh_reg[BYTE_W-1:1]};
            tx_line_next = tx_sh_reg[1];
            tx_bit_next = tx_bit_reg + 1'b1;
          end
        end
        LN_STOP: tx_st_next = LN_IDLE;
        default: tx_st_next = LN_IDLE;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_st_reg <= LN_IDLE;
      tx_div_reg <= '0;
      tx_bit_reg <= '0;
      tx_sh_reg <= '0;
      tx_line_reg <= 1'b1;
    end else if (ce) begin
      tx_st_reg <= tx_st_next;
      tx_div_reg <= tx_div_next;
      tx_bit_reg <= tx_bit_next;
      tx_sh_reg <= tx_sh_next;
      tx_line_reg <= tx_line_next;
    end
  end

  // bus slave, registers and block engines
  logic dp_vld_reg, dp_vld_next, dp_wr_reg, dp_wr_next;
  logic [IDX_W-1:0] dp_idx_reg, dp_idx_next;
  logic [DATA_W-1:0] hrdata_reg, hrdata_next;
  logic [PTR_W-1:0] rx_base_reg, rx_base_next, tx_base_reg, tx_base_next;
  logic [PTR_W-1:0] rx_ptr_reg, rx_ptr_next, tx_ptr_reg, tx_ptr_next;
  logic [CNT_W-1:0] rx_len_reg, rx_len_next, tx_len_reg, tx_len_next;
  logic rx_act_reg, rx_act_next, tx_act_reg, tx_act_next;
  logic tx_hold_vld_next;
  logic [BYTE_W-1:0] tx_hold_next;
  logic [IRQ_W-1:0] sts_reg, sts_next, en_reg, en_next, sts_set;
  fsb_mem_t ms_reg, ms_next;
  logic mem_we_reg, mem_we_next;
  logic [PTR_W-1:0] mem_addr_reg, mem_addr_next;
  logic [BYTE_W-1:0] mem_wdata_reg, mem_wdata_next;
  logic acc, wr_dp, cpu_pop, eng_pop;
  logic [IDX_W-1:0] a_idx;
  logic [DATA_W-1:0] rd_val;

  assign acc = hsel && (htrans & HTRANS_NONSEQ_BIT) != '0 && hready && ce;
  assign a_idx = idx_of(haddr);
  assign wr_dp = dp_vld_reg && dp_wr_reg;
  // block receive owns the fifo; cpu reads then do not drain it
  assign cpu_pop = acc && !hwrite && a_idx == IDX_DATA
                   && !rx_act_reg && !fifo_empty; // [RQ1]
  assign eng_pop = ms_reg == MS_IDLE && rx_act_reg && !fifo_empty;
  assign rx_pop = cpu_pop || eng_pop;

  always_comb begin
    rd_val = '0;
    case (a_idx)
      IDX_DATA: rd_val[BYTE_W-1:0] = rx_mem[rx_rp_reg]; // [RQ1] [RQ5]
      IDX_RX_BASE: rd_val[PTR_W-1:0] = rx_base_reg;
      IDX_RX_CNT: rd_val[CNT_W-1:0] = rx_len_reg; // [RQ9] [RQ13]
      IDX_TX_BASE: rd_val[PTR_W-1:0] = tx_base_reg;
      IDX_TX_CNT: rd_val[CNT_W-1:0] = tx_len_reg; // [RQ12] [RQ13]
      IDX_IRQ_STS: rd_val[IRQ_W-1:0] = sts_reg;
      IDX_IRQ_EN: rd_val[IRQ_W-1:0] = en_reg;
      IDX_LINE_STS: begin
        rd_val[LS_RX_READY] = !fifo_empty; // [RQ16]
        rd_val[LS_TX_READY] = !tx_hold_vld_reg; // [RQ15]
        rd_val[LS_RX_FULL] = fifo_full;
        rd_val[LS_RX_BUSY] = rx_act_reg;
        rd_val[LS_TX_BUSY] = tx_act_reg;
      end
      default: rd_val = '0;
    endcase
  end

  always_comb begin
    dp_vld_next = acc;
    dp_wr_next = hwrite;
    dp_idx_next = a_idx;
    hrdata_next = (acc && !hwrite) ? rd_val : hrdata_reg;
    rx_base_next = rx_base_reg;
    tx_base_next = tx_base_reg;
    rx_ptr_next = rx_ptr_reg;
    tx_ptr_next = tx_ptr_reg;
    rx_len_next = rx_len_reg;
    tx_len_next = tx_len_reg;
    rx_act_next = rx_act_reg;
    tx_act_next = tx_act_reg;
    tx_hold_vld_next = tx_hold_vld_reg && !tx_take;
    tx_hold_next = tx_hold_reg;
    en_next = en_reg;
    ms_next = ms_reg;
    mem_we_next = mem_we_reg;
    mem_addr_next = mem_addr_reg;
    mem_wdata_next = mem_wdata_reg;
    sts_set = '0;
    sts_set[IRQ_RX_OVF] = rx_push && fifo_full;
    case (ms_reg)
      MS_IDLE: begin
        // receive side first; each side advances only its own pointer
        if (eng_pop) begin
          ms_next = MS_RXWR;
          mem_we_next = 1'b1;
          mem_addr_next = rx_ptr_reg; // [RQ18]
          mem_wdata_next = rx_mem[rx_rp_reg];
        end else if (tx_act_reg && !tx_hold_vld_reg) begin
          ms_next = MS_TXRD;
          mem_we_next = 1'b0;
          mem_addr_next = tx_ptr_reg; // [RQ18]
        end
      end
      MS_RXWR: begin
        if (mem_ack) begin
          ms_next = MS_IDLE;
          rx_ptr_next = rx_ptr_reg + PTR_STEP; // [RQ18] [RQ19]
          rx_len_next = count_down(rx_len_reg); // [RQ9] [RQ14]
          if (rx_len_reg == CNT_RESET) begin
            rx_act_next = 1'b0;
            sts_set[IRQ_RX_DONE] = 1'b1; // [RQ17]
          end
        end
      end
      MS_TXRD: begin
        if (mem_ack) begin
          ms_next = MS_IDLE;
          tx_hold_vld_next = 1'b1;
          tx_hold_next = mem_rdata;
          tx_ptr_next = tx_ptr_reg + PTR_STEP; // [RQ18] [RQ19]
          tx_len_next = count_down(tx_len_reg); // [RQ12] [RQ14]
          if (tx_len_reg == CNT_RESET) begin
            tx_act_next = 1'b0;
            sts_set[IRQ_TX_DONE] = 1'b1; // [RQ17]
          end
        end
      end
      default: ms_next = MS_IDLE;
    endcase
    sts_next = sts_reg;
    if (wr_dp) begin
      case (dp_idx_reg)
        IDX_DATA: begin
          // overwrites a pending byte if software ignores transmit-ready
          tx_hold_vld_next = 1'b1; // [RQ3]
          tx_hold_next = hwdata[BYTE_W-1:0]; // [RQ5]
        end
        IDX_RX_BASE: rx_base_next = hwdata[PTR_W-1:0]; // [RQ7]
        IDX_TX_BASE: tx_base_next = hwdata[PTR_W-1:0]; // [RQ10]
        IDX_RX_CNT: begin
          rx_len_next = hwdata[CNT_W-1:0]; // [RQ8] [RQ13]
          rx_ptr_next = rx_base_reg; // [RQ7]
          rx_act_next = 1'b1; // [RQ8]
        end
        IDX_TX_CNT: begin
          tx_len_next = hwdata[CNT_W-1:0]; // [RQ11] [RQ13]
          tx_ptr_next = tx_base_reg; // [RQ10]
          tx_act_next = 1'b1; // [RQ11]
        end
        IDX_IRQ_EN: en_next = hwdata[IRQ_W-1:0];
        IDX_IRQ_CLR: sts_next = sts_reg & ~hwdata[IRQ_W-1:0]; // [RQ17]
        default: sts_next = sts_reg;
      endcase
    end
    // a new event beats a clear in the same cycle
    sts_next = sts_next | sts_set; // [RQ17]
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_vld_reg <= 1'b0;
      dp_wr_reg <= 1'b0;
      dp_idx_reg <= '0;
      hrdata_reg <= '0;
      rx_base_reg <= PTR_RESET;
      tx_base_reg <= PTR_RESET;
      rx_ptr_reg <= PTR_RESET;
      tx_ptr_reg <= PTR_RESET;
      rx_len_reg <= CNT_RESET;
      tx_len_reg <= CNT_RESET;
      rx_act_reg <= 1'b0;
      tx_act_reg <= 1'b0;
      tx_hold_vld_reg <= 1'b0;
      tx_hold_reg <= '0;
      sts_reg <= '0;
      en_reg <= '0;
      ms_reg <= MS_IDLE;
      mem_we_reg <= 1'b0;
      mem_addr_reg <= PTR_RESET;
      mem_wdata_reg <= '0;
    end else if (ce) begin
      dp_vld_reg <= dp_vld_next;
      dp_wr_reg <= dp_wr_next;
      dp_idx_reg <= dp_idx_next;
      hrdata_reg <= hrdata_next;
      rx_base_reg <= rx_base_next;
      tx_base_reg <= tx_base_next;
      rx_ptr_reg <= rx_ptr_next;
      tx_ptr_reg <= tx_ptr_next;
      rx_len_reg <= rx_len_next;
      tx_len_reg <= tx_len_next;
      rx_act_reg <= rx_act_next;
      tx_act_reg <= tx_act_next;
      tx_hold_vld_reg <= tx_hold_vld_next;
      tx_hold_reg <= tx_hold_next;
      sts_reg <= sts_next;
      en_reg <= en_next;
      ms_reg <= ms_next;
      mem_we_reg <= mem_we_next;
      mem_addr_reg <= mem_addr_next;
      mem_wdata_reg <= mem_wdata_next;
    end
  end

  // wait states while frozen keep bus writes from being lost
  assign hreadyout = ce;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;
  assign tx_line = tx_line_reg;
  assign mem_req = ms_reg != MS_IDLE;
  assign mem_we = mem_we_reg;
  assign mem_addr = mem_addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign irq = |(sts_reg & en_reg);
endmodule

/* fsb_pkg.sv */
// constants and types for the fast serial port block transfer unit
// assumes a 32-bit ahb-lite bus and a byte-wide memory port
// Contract
// (RQ1) data register read returns latest received byte, single-byte mode only; code returns the oldest unread fifo byte instead.
// (RQ2) software trusts read data only while receive-ready reads one.
// (RQ3) each data register write sends exactly one byte on the line; code overwrites a still-pending hold byte, which is never sent.
// (RQ4) software writes data register only while transmit-ready reads one.
// (RQ5) data register holds the byte in bits 7:0, upper bits unused.
// (RQ6) software writes zero to reserved bits of data and counter registers.
// (RQ7) 16-bit receive base pointer feeds the next block receive.
// (RQ8) loading receive counter with length minus one starts block receive.
// (RQ9) receive counter decrements per byte and reads remaining length.
// (RQ10) 16-bit transmit base pointer feeds the next block transmit.
// (RQ11) loading transmit counter with length minus one starts block transmit.
// (RQ12) transmit counter decrements per byte and reads remaining length.
// (RQ13) counters are 10 bits in 9:0, max 0x03ff, upper bits reserved.
// (RQ14) finished counter reads 0x03ff until software reloads it.
// (RQ15) transmit-ready reads one when the transmit buffer can take a byte.
// (RQ16) receive-ready reads one when the receive fifo holds a byte.
// (RQ17) block completion sets a done flag, cleared by writing one.
// (RQ18) block bytes move from the base pointer, address advancing per byte.
// (RQ19) receive and transmit engines run independently on their own registers.
package fsb_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int IDX_W = 16;
  localparam int BYTE_W = 8;
  localparam int CNT_W = 10;
  localparam int PTR_W = 16;
  // register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_DATA = 16'hc076;
  localparam logic [IDX_W-1:0] IDX_RX_BASE = 16'hc078;
  localparam logic [IDX_W-1:0] IDX_RX_CNT = 16'hc07a;
  localparam logic [IDX_W-1:0] IDX_TX_BASE = 16'hc07c;
  localparam logic [IDX_W-1:0] IDX_TX_CNT = 16'hc07e;
  localparam logic [IDX_W-1:0] IDX_IRQ_STS = 16'hc080;
  localparam logic [IDX_W-1:0] IDX_IRQ_EN = 16'hc082;
  localparam logic [IDX_W-1:0] IDX_IRQ_CLR = 16'hc084;
  localparam logic [IDX_W-1:0] IDX_LINE_STS = 16'hc086;
  localparam int IDX_LSB = 2;
  localparam logic [CNT_W-1:0] CNT_RESET = 10'h000;
  localparam logic [CNT_W-1:0] CNT_DONE = 10'h3ff;
  localparam logic [PTR_W-1:0] PTR_RESET = 16'h0000;
  localparam logic [PTR_W-1:0] PTR_STEP = 16'h0001;
  // interrupt status / enable / clear layout
  localparam int IRQ_W = 3;
  localparam int IRQ_RX_DONE = 0;
  localparam int IRQ_TX_DONE = 1;
  localparam int IRQ_RX_OVF = 2;
  // line status layout
  localparam int LS_RX_READY = 0;
  localparam int LS_TX_READY = 1;
  localparam int LS_RX_FULL = 2;
  localparam int LS_RX_BUSY = 3;
  localparam int LS_TX_BUSY = 4;
  // timing: 2.0 Mbaud line at 125 MHz
  localparam int CLK_MHZ = 125;
  localparam int BIT_TIME_NS = 500;
  localparam int CLKS_PER_BIT = BIT_TIME_NS * CLK_MHZ / 1000;
  localparam int RX_FIFO_DEPTH = 8;
  localparam logic [1:0] HTRANS_NONSEQ_BIT = 2'b10;
  localparam logic HRESP_OKAY = 1'b0;
  typedef enum logic [1:0] {LN_IDLE, LN_START, LN_DATA, LN_STOP} fsb_line_t;
  typedef enum logic [1:0] {MS_IDLE, MS_RXWR, MS_TXRD} fsb_mem_t;
endpackage

/* fsb_block_transfer_monitor.sv */
// assertion checker for the fast serial port block transfer unit
// assumes it is bound onto the design top and sees only its ports
`timescale 1ns/1ps
module fsb_block_transfer_monitor #(
  parameter int CLKS_PER_BIT = fsb_pkg::CLKS_PER_BIT
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [fsb_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [fsb_pkg::DATA_W-1:0] hrdata,
  input wire logic tx_line,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [fsb_pkg::PTR_W-1:0] mem_addr,
  input wire logic [fsb_pkg::BYTE_W-1:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic irq
);
  import fsb_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [15:0] low_run_reg, low_run_next, high_run_reg, high_run_next;
  logic taken;
  assign taken = hsel && htrans[1] && hready && ce;
  // high run saturates so a long idle line never wraps to a short one
  always_comb begin
    low_run_next = tx_line ? 16'h0 : low_run_reg + 16'h1;
    high_run_next = !tx_line ? 16'h0 :
      (&high_run_reg ? high_run_reg : high_run_reg + 16'h1);
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      low_run_reg <= 16'h0;
      high_run_reg <= 16'hffff;
    end else begin
      low_run_reg <= low_run_next;
      high_run_reg <= high_run_next;
    end
  end
  a_low_cells: assert property (
    $rose(tx_line) |-> low_run_reg != 16'h0 &&
      low_run_reg % CLKS_PER_BIT == 0) else $error("bad low cell length");
  a_stop_gap: assert property (
    $fell(tx_line) |-> high_run_reg >= CLKS_PER_BIT)
    else $error("stop bit too short");
  // only from a quiet line; a write mid-frame waits in the hold buffer
  a_write_sends: assert property (
    taken && hwrite && haddr[17:2] == IDX_DATA &&
      high_run_reg > 10 * CLKS_PER_BIT |-> ##[1:4] !tx_line)
    else $error("data write sent nothing");
  a_req_drop: assert property (
    mem_req && mem_ack |=> !mem_req) else $error("request not dropped");
  a_req_hold: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) &&
      $stable(mem_we) && $stable(mem_wdata)) else $error("request moved");
  a_dir_idle: assert property (
    $changed(mem_we) |-> $rose(mem_req))
    else $error("direction changed in access");
  a_rdata_hold: assert property (
    $changed(hrdata) |-> $past(taken && !hwrite))
    else $error("read data changed without read");
  a_zero_wait: assert property (hreadyout == ce)
    else $error("ready does not follow enable");
  a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
  a_reset_out: assert property ($rose(hresetn) |-> tx_line && !mem_req &&
    !irq && hrdata == '0) else $error("outputs not idle after reset");
  c_rx_write: cover property (mem_req && mem_ack && mem_we);
  c_tx_read: cover property (mem_req && mem_ack && !mem_we);
  c_irq: cover property ($rose(irq));
endmodule
bind fsb_block_transfer fsb_block_transfer_monitor #(
  .CLKS_PER_BIT(CLKS_PER_BIT)
) i_mon (.hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .tx_line(tx_line),
  .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_wdata(mem_wdata), .mem_ack(mem_ack), .irq(irq));

/* fsb_remote.sv */
// remote serial device: sends frames on rx_line, decodes tx_line
// assumes 8n1 lsb first, CPB clocks per bit, line idle high
`timescale 1ns/1ps
module fsb_remote #(
  parameter int CPB = 4
) (
  input wire logic hclk,
  input wire logic tx_line,
  output logic rx_line,
  output logic got_vld,
  output logic [7:0] got_byte
);
  initial begin
    rx_line = 1'b1;
    got_vld = 1'b0;
    got_byte = 8'h00;
  end
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge hclk);
      rx_line <= f[i];
      repeat (CPB - 1) @(posedge hclk);
    end
  endtask
  // samples mid cell; a low stop bit drops the byte
  initial forever begin
    @(negedge tx_line);
    repeat (CPB / 2) @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      repeat (CPB) @(posedge hclk);
      got_byte[i] <= tx_line;
    end
    repeat (CPB) @(posedge hclk);
    got_vld <= tx_line;
    @(posedge hclk);
    got_vld <= 1'b0;
  end
endmodule

/* fsb_block_transfer_bench.sv */
// bench for the fast serial port block transfer unit
// assumes the remote line model; byte memory modelled here
`timescale 1ns/1ps
module fsb_block_transfer_bench;
  import fsb_pkg::*;
  localparam int CPB = 4;
  logic hclk = 0;
  logic hresetn = 0;
  logic hsel = 0;
  logic hwrite = 0;
  logic mem_ack = 0;
  logic ce = 1;
  logic rd_ph = 0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [7:0] mem_rdata = '0;
  logic [7:0] mem_wdata;
  logic [7:0] got_byte;
  logic [15:0] mem_addr;
  logic hreadyout, hresp, rx_line, tx_line, mem_req, mem_we, irq, got_vld;
  int n_errors = 0;
  int checked = 0;
  int seed = 65;
  int n_memw = 0;
  logic [31:0] rd_q[$];
  logic [7:0] tx_q[$];
  logic [23:0] mw_q[$];
  fsb_block_transfer #(.CLKS_PER_BIT(CPB), .RX_DEPTH(8)) i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rx_line(rx_line), .tx_line(tx_line),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
    .irq(irq));
  fsb_remote #(.CPB(CPB)) i_rem (.hclk(hclk), .tx_line(tx_line),
    .rx_line(rx_line), .got_vld(got_vld), .got_byte(got_byte));
  initial forever #4 hclk = ~hclk;
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // memory answers at random pace; idle data toggles so stale bytes show
  always @(posedge hclk) begin
    mem_ack <= mem_req && !mem_ack && ($random(seed) % 3 != 0);
    mem_rdata <= mem_req ? mem_addr[7:0] ^ 8'h5a : ~mem_rdata;
  end
  always @(posedge hclk) begin
    if (rd_ph && hreadyout) cmp(hrdata, rd_q.pop_front());
    if (got_vld) cmp({24'h0, got_byte}, {24'h0, tx_q.pop_front()});
    if (mem_req && mem_ack && mem_we) begin
      cmp({8'h0, mem_addr, mem_wdata}, {8'h0, mw_q.pop_front()});
      n_memw++;
    end
  end
  task automatic bus(input logic w, input logic [15:0] idx,
      input logic [31:0] wd, input logic [31:0] exp, input logic chk,
      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ_BIT;
    hwrite <= w;
    haddr <= {14'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    rd_ph <= !w && chk;
    if (!w && chk) rd_q.push_back(exp);
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    rd_ph <= 1'b0;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, '0, 1'b0, r);
  endtask
  task automatic rdc(input logic [15:0] idx, input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, idx, '0, e, 1'b1, r);
  endtask
  task automatic poll(input int b, input logic v);
    logic [31:0] r;
    int k;
    k = 0;
    do begin
      bus(1'b0, IDX_LINE_STS, '0, '0, 1'b0, r);
      k++;
    end while (r[b] !== v && k < 3000);
  endtask
  initial begin
    repeat (20000) @(posedge hclk);
    n_errors++;
    end_of_test();
  end
  initial begin
    logic [15:0] rb, tb;
    logic [7:0] b;
    logic [31:0] r;
    rb = 16'($random(seed));
    tb = 16'($random(seed));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 4; i++) rdc(IDX_RX_BASE + 16'(2 * i), '0);
    rdc(16'h0123, '0);
    // a frozen clock enable must stretch the address phase
    ce <= 1'b0;
    fork
      begin
        repeat (3) @(posedge hclk);
        ce <= 1'b1;
      end
      wr(IDX_RX_BASE, {16'h0, rb});
    join
    wr(IDX_TX_BASE, {16'h0, tb});
    rdc(IDX_RX_BASE, {16'h0, rb});
    rdc(IDX_TX_BASE, {16'h0, tb});
    for (int i = 0; i < 2; i++) begin
      b = 8'($random(seed));
      poll(LS_TX_READY, 1'b1);
      tx_q.push_back(b);
      wr(IDX_DATA, {24'h0, b});
    end
    b = 8'($random(seed));
    i_rem.send(b);
    poll(LS_RX_READY, 1'b1);
    rdc(IDX_DATA, {24'h0, b});
    bus(1'b0, IDX_LINE_STS, '0, '0, 1'b0, r);
    cmp(r[LS_RX_READY], 1'b0);
    // ninth byte finds the fifo full and is lost
    for (int i = 0; i < 9; i++) i_rem.send(8'(i));
    rdc(IDX_LINE_STS, 32'h7);
    rdc(IDX_IRQ_STS, 32'h4);
    for (int i = 0; i < 8; i++) rdc(IDX_DATA, 32'(i));
    wr(IDX_IRQ_CLR, 32'h4);
    rdc(IDX_IRQ_STS, 32'h0);
    wr(IDX_IRQ_EN, 32'h7);
    for (int i = 0; i < 3; i++)
      mw_q.push_back({rb + 16'(i), 8'(8'h30 + i)});
    wr(IDX_RX_CNT, 32'h2);
    i_rem.send(8'h30);
    for (int k = 0; k < 60 && n_memw < 1; k++) @(posedge hclk);
    rdc(IDX_RX_CNT, 32'h1);
    i_rem.send(8'h31);
    i_rem.send(8'h32);
    poll(LS_RX_BUSY, 1'b0);
    rdc(IDX_RX_CNT, {22'h0, CNT_DONE});
    rdc(IDX_IRQ_STS, 32'h1);
    @(negedge hclk);
    cmp(irq, 1'b1);
    wr(IDX_IRQ_CLR, 32'h1);
    rdc(IDX_IRQ_STS, 32'h0);
    wr(IDX_IRQ_EN, 32'h1);
    for (int i = 0; i < 2; i++)
      tx_q.push_back(8'(tb + 16'(i)) ^ 8'h5a);
    wr(IDX_TX_CNT, 32'h1);
    poll(LS_TX_BUSY, 1'b0);
    rdc(IDX_TX_CNT, {22'h0, CNT_DONE});
    rdc(IDX_IRQ_STS, 32'h2);
    cmp(irq, 1'b0);
    wr(IDX_IRQ_EN, 32'h2);
    @(negedge hclk);
    cmp(irq, 1'b1);
    wr(IDX_IRQ_CLR, 32'h2);
    @(negedge hclk);
    cmp(irq, 1'b0);
    for (int k = 0; k < 400 && tx_q.size() > 0; k++) @(posedge hclk);
    cmp(tx_q.size(), 0);
    cmp(mw_q.size(), 0);
    end_of_test();
  end
endmodule
